// >>> hw/ppdl_defs.vh
// Register offsets, sub-register indices and reset values for the port and LED block
`ifndef PPDL_DEFS_VH
`define PPDL_DEFS_VH
`define PPDL_ADDR_W 12
`define PPDL_OFS_LED_EN 12'hF82
`define PPDL_OFS_LED_UP 12'hF83
`define PPDL_OFS_LED_LO 12'hF84
`define PPDL_OFS_PA_IN 12'hFD2
`define PPDL_OFS_PA_OUT 12'hFD3
`define PPDL_OFS_PB_IN 12'hFD6
`define PPDL_OFS_PB_OUT 12'hFD7
`define PPDL_OFS_PC_IN 12'hFDA
`define PPDL_OFS_PC_OUT 12'hFDB
`define PPDL_OFS_PA_IDX 12'hFD0
`define PPDL_OFS_PA_CTL 12'hFD1
`define PPDL_OFS_PB_IDX 12'hFD4
`define PPDL_OFS_PB_CTL 12'hFD5
`define PPDL_OFS_PC_IDX 12'hFD8
`define PPDL_OFS_PC_CTL 12'hFD9
`define PPDL_SUB_DIR 8'h01
`define PPDL_SUB_AFEN 8'h02
`define PPDL_SUB_ODRAIN 8'h03
`define PPDL_SUB_FSEL1 8'h07
`define PPDL_SUB_FSEL2 8'h08
`define PPDL_RST_ZERO 8'h00
`define PPDL_RST_DIR 8'hFF
`define PPDL_RST_FSEL_SMALL_A 8'h04
`endif

// >>> hw/ppdl_port.v
// One GPIO port: indexed sub-registers, drive value and pin drive logic
`timescale 1ns/1ps
`include "ppdl_defs.vh"
module ppdl_port #(
    parameter [7:0] FSEL_RST = 8'h00,
    parameter [7:0] PIN_MASK = 8'hFF
) (
    input wire clk_sys,
    input wire rst_n,
    input wire idx_we,
    input wire ctl_we,
    input wire out_we,
    input wire [7:0] wdata,
    input wire [7:0] pin_in,
    output reg [7:0] ctl_rdata,
    output wire [7:0] idx_q,
    output wire [7:0] drive_value,
    output wire [7:0] pin_sample,
    output wire [7:0] pin_out,
    output wire [7:0] pin_oe_n,
    output wire [7:0] alt_function_enable,
    output wire [7:0] first_select_bits,
    output wire [7:0] second_select_bits,
    output wire [7:0] open_drain_select,
    input wire [7:0] alt_out,
    input wire [7:0] alt_oe
);
    reg [7:0] idx_ff;
    reg [7:0] dir_ff;
    reg [7:0] afen_ff;
    reg [7:0] odr_ff;
    reg [7:0] fs1_ff;
    reg [7:0] fs2_ff;
    reg [7:0] out_ff;
    reg [7:0] smp_ff;
    wire [7:0] pin_direction;
    wire [7:0] want_drive;
    wire [7:0] level;

    // Index and sub-register storage, selected by the held index
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            idx_ff <= `PPDL_RST_ZERO;
            dir_ff <= `PPDL_RST_DIR;
            afen_ff <= `PPDL_RST_ZERO;
            odr_ff <= `PPDL_RST_ZERO;
            fs1_ff <= FSEL_RST;
            fs2_ff <= `PPDL_RST_ZERO;
            out_ff <= `PPDL_RST_ZERO;
        end else begin
            if (idx_we)
                idx_ff <= wdata;
            if (out_we)
                out_ff <= wdata;
            if (ctl_we) begin
                case (idx_ff)
                    `PPDL_SUB_DIR: dir_ff <= wdata;
                    `PPDL_SUB_AFEN: afen_ff <= wdata;
                    `PPDL_SUB_ODRAIN: odr_ff <= wdata;
                    `PPDL_SUB_FSEL1: fs1_ff <= wdata;
                    `PPDL_SUB_FSEL2: fs2_ff <= wdata;
                    default: ;
                endcase
            end
        end
    end

    // Pin levels sampled each clock; absent pins read zero
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            smp_ff <= `PPDL_RST_ZERO;
        else
            smp_ff <= pin_in & PIN_MASK;
    end

    // Control port read-back of the selected sub-register
    always @* begin
        case (idx_ff)
            `PPDL_SUB_DIR: ctl_rdata = dir_ff;
            `PPDL_SUB_AFEN: ctl_rdata = afen_ff;
            `PPDL_SUB_ODRAIN: ctl_rdata = odr_ff;
            `PPDL_SUB_FSEL1: ctl_rdata = fs1_ff;
            `PPDL_SUB_FSEL2: ctl_rdata = fs2_ff;
            default: ctl_rdata = `PPDL_RST_ZERO;
        endcase
    end

    // Direction bit 1 means input
    assign pin_direction = dir_ff;
    // Alternate function owns the pin when enabled, else direction decides
    assign want_drive = (afen_ff & alt_oe) | (~afen_ff & ~pin_direction);
    assign level = (afen_ff & alt_out) | (~afen_ff & out_ff);
    // Open drain suppresses the high drive in every mode
    assign pin_oe_n = ~(want_drive & ~(odr_ff & level) & PIN_MASK);
    assign pin_out = level;
    assign idx_q = idx_ff;
    assign drive_value = out_ff;
    assign pin_sample = smp_ff;
    assign alt_function_enable = afen_ff;
    assign first_select_bits = fs1_ff;
    assign second_select_bits = fs2_ff;
    assign open_drain_select = odr_ff;
endmodule // ppdl_port

// >>> hw/ppdl_led.v
// Port C LED current sink enable and drive level registers
`timescale 1ns/1ps
`include "ppdl_defs.vh"
module ppdl_led (
    input wire clk_sys,
    input wire rst_n,
    input wire en_we,
    input wire up_we,
    input wire lo_we,
    input wire [7:0] wdata,
    output reg [7:0] led_sink_enable,
    output reg [7:0] led_level_upper_bits,
    output reg [7:0] led_level_lower_bits,
    output wire [15:0] sink_level
);
    // Three byte registers, each pin independent
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            led_sink_enable <= `PPDL_RST_ZERO;
            led_level_upper_bits <= `PPDL_RST_ZERO;
            led_level_lower_bits <= `PPDL_RST_ZERO;
        end else begin
            if (en_we)
                led_sink_enable <= wdata;
            if (up_we)
                led_level_upper_bits <= wdata;
            if (lo_we)
                led_level_lower_bits <= wdata;
        end
    end

    // Two-bit code per pin: upper bit high, lower bit low
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_lvl
            assign sink_level[2*g+1:2*g] = {led_level_upper_bits[g],
                                            led_level_lower_bits[g]};
        end
    endgenerate
endmodule // ppdl_led

// >>> hw/ppdl_top.v
// GPIO ports A to C with register slave and Port C LED sink control
`timescale 1ns/1ps
`include "ppdl_defs.vh"
module ppdl_top #(
    parameter SMALL_PKG = 0,
    parameter [7:0] PA_MASK = 8'hFF,
    parameter [7:0] PB_MASK = 8'hFF,
    parameter [7:0] PC_MASK = 8'hFF
) (
    input wire clk_sys,
    input wire rst_n,
    input wire [11:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire [23:0] pin_in,
    output wire [23:0] pin_out,
    output wire [23:0] pin_oe_n,
    input wire [23:0] alt_out,
    input wire [23:0] alt_oe,
    output wire [23:0] alt_function_enable,
    output wire [23:0] first_select_bits,
    output wire [23:0] second_select_bits,
    output wire [7:0] led_sink_on,
    output wire [15:0] led_sink_level
);
    reg rst_s1_ff;
    reg rst_s2_ff;
    wire rst_sync_n;
    wire [7:0] idx_q [0:2];
    wire [7:0] ctl_q [0:2];
    wire [7:0] out_q [0:2];
    wire [7:0] smp_q [0:2];
    wire [23:0] odr_all;
    wire [7:0] led_en;
    wire [7:0] led_up;
    wire [7:0] led_lo;
    reg [7:0] nxt_rdata;

    // Reset release through two flip-flops
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end
    assign rst_sync_n = rst_s2_ff;

    // Write strobe decode for one address
    function hit;
        input [11:0] a;
        input [11:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction

    ppdl_port #(
        .FSEL_RST(SMALL_PKG ? `PPDL_RST_FSEL_SMALL_A : `PPDL_RST_ZERO),
        .PIN_MASK(PA_MASK)
    ) u_pa (
        .clk_sys(clk_sys), .rst_n(rst_sync_n),
        .idx_we(reg_wr & hit(reg_addr, `PPDL_OFS_PA_IDX)),
        .ctl_we(reg_wr & hit(reg_addr, `PPDL_OFS_PA_CTL)),
        .out_we(reg_wr & hit(reg_addr, `PPDL_OFS_PA_OUT)),
        .wdata(reg_wdata), .pin_in(pin_in[7:0]),
        .ctl_rdata(ctl_q[0]), .idx_q(idx_q[0]), .drive_value(out_q[0]),
        .pin_sample(smp_q[0]), .pin_out(pin_out[7:0]), .pin_oe_n(pin_oe_n[7:0]),
        .alt_function_enable(alt_function_enable[7:0]),
        .first_select_bits(first_select_bits[7:0]),
        .second_select_bits(second_select_bits[7:0]),
        .open_drain_select(odr_all[7:0]),
        .alt_out(alt_out[7:0]), .alt_oe(alt_oe[7:0])
    );

    ppdl_port #(
        .FSEL_RST(`PPDL_RST_ZERO),
        .PIN_MASK(PB_MASK)
    ) u_pb (
        .clk_sys(clk_sys), .rst_n(rst_sync_n),
        .idx_we(reg_wr & hit(reg_addr, `PPDL_OFS_PB_IDX)),
        .ctl_we(reg_wr & hit(reg_addr, `PPDL_OFS_PB_CTL)),
        .out_we(reg_wr & hit(reg_addr, `PPDL_OFS_PB_OUT)),
        .wdata(reg_wdata), .pin_in(pin_in[15:8]),
        .ctl_rdata(ctl_q[1]), .idx_q(idx_q[1]), .drive_value(out_q[1]),
        .pin_sample(smp_q[1]), .pin_out(pin_out[15:8]), .pin_oe_n(pin_oe_n[15:8]),
        .alt_function_enable(alt_function_enable[15:8]),
        .first_select_bits(first_select_bits[15:8]),
        .second_select_bits(second_select_bits[15:8]),
        .open_drain_select(odr_all[15:8]),
        .alt_out(alt_out[15:8]), .alt_oe(alt_oe[15:8])
    );

    ppdl_port #(
        .FSEL_RST(`PPDL_RST_ZERO),
        .PIN_MASK(PC_MASK)
    ) u_pc (
        .clk_sys(clk_sys), .rst_n(rst_sync_n),
        .idx_we(reg_wr & hit(reg_addr, `PPDL_OFS_PC_IDX)),
        .ctl_we(reg_wr & hit(reg_addr, `PPDL_OFS_PC_CTL)),
        .out_we(reg_wr & hit(reg_addr, `PPDL_OFS_PC_OUT)),
        .wdata(reg_wdata), .pin_in(pin_in[23:16]),
        .ctl_rdata(ctl_q[2]), .idx_q(idx_q[2]), .drive_value(out_q[2]),
        .pin_sample(smp_q[2]), .pin_out(pin_out[23:16]), .pin_oe_n(pin_oe_n[23:16]),
        .alt_function_enable(alt_function_enable[23:16]),
        .first_select_bits(first_select_bits[23:16]),
        .second_select_bits(second_select_bits[23:16]),
        .open_drain_select(odr_all[23:16]),
        .alt_out(alt_out[23:16]), .alt_oe(alt_oe[23:16])
    );

    ppdl_led u_led (
        .clk_sys(clk_sys), .rst_n(rst_sync_n),
        .en_we(reg_wr & hit(reg_addr, `PPDL_OFS_LED_EN)),
        .up_we(reg_wr & hit(reg_addr, `PPDL_OFS_LED_UP)),
        .lo_we(reg_wr & hit(reg_addr, `PPDL_OFS_LED_LO)),
        .wdata(reg_wdata),
        .led_sink_enable(led_en),
        .led_level_upper_bits(led_up),
        .led_level_lower_bits(led_lo),
        .sink_level(led_sink_level)
    );

    // Sink is connected only by its enable bit; software must pick LED function first
    assign led_sink_on = led_en & PC_MASK;

    // Read mux; input registers ignore writes, unmapped reads zero
    always @* begin
        case (reg_addr)
            `PPDL_OFS_LED_EN: nxt_rdata = led_en;
            `PPDL_OFS_LED_UP: nxt_rdata = led_up;
            `PPDL_OFS_LED_LO: nxt_rdata = led_lo;
            `PPDL_OFS_PA_IDX: nxt_rdata = idx_q[0];
            `PPDL_OFS_PA_CTL: nxt_rdata = ctl_q[0];
            `PPDL_OFS_PA_IN: nxt_rdata = smp_q[0];
            `PPDL_OFS_PA_OUT: nxt_rdata = out_q[0];
            `PPDL_OFS_PB_IDX: nxt_rdata = idx_q[1];
            `PPDL_OFS_PB_CTL: nxt_rdata = ctl_q[1];
            `PPDL_OFS_PB_IN: nxt_rdata = smp_q[1];
            `PPDL_OFS_PB_OUT: nxt_rdata = out_q[1];
            `PPDL_OFS_PC_IDX: nxt_rdata = idx_q[2];
            `PPDL_OFS_PC_CTL: nxt_rdata = ctl_q[2];
            `PPDL_OFS_PC_IN: nxt_rdata = smp_q[2];
            `PPDL_OFS_PC_OUT: nxt_rdata = out_q[2];
            default: nxt_rdata = `PPDL_RST_ZERO;
        endcase
    end

    // Read data registered, valid in the cycle after the strobe only
    always @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n)
            reg_rdata <= `PPDL_RST_ZERO;
        else if (reg_rd)
            reg_rdata <= nxt_rdata;
        else
            reg_rdata <= `PPDL_RST_ZERO;
    end
endmodule // ppdl_top

// >>> tb/ppdl_chk_asserts.sv
// Checker of register and pin behaviour of the port and LED block
`timescale 1ns/1ps
module ppdl_chk #(
    parameter [7:0] PA_MASK = 8'hFF,
    parameter [7:0] PC_MASK = 8'hFF
) (
    input wire clk_sys,
    input wire rst_n,
    input wire [11:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire [23:0] pin_in,
    input wire [23:0] pin_out,
    input wire [23:0] pin_oe_n,
    input wire [23:0] alt_out,
    input wire [23:0] alt_oe,
    input wire [23:0] alt_function_enable,
    input wire [23:0] first_select_bits,
    input wire [23:0] second_select_bits,
    input wire [7:0] led_sink_on,
    input wire [15:0] led_sink_level
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire [7:0] pa_in = pin_in[7:0];
    logic [7:0] lvl_up;
    logic [7:0] lvl_lo;
    // Split the per-pin level codes into upper and lower bytes
    always_comb begin
        for (int g = 0; g < 8; g++) begin
            lvl_up[g] = led_sink_level[2*g+1];
            lvl_lo[g] = led_sink_level[2*g];
        end
    end
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    pin_read_a: assert property (reg_rd && reg_addr == 12'hFD2 && $stable(pin_in) |=>
        reg_rdata == ($past(pa_in) & PA_MASK)) else $error("pin sample read wrong");
    sink_on_a: assert property (reg_wr && reg_addr == 12'hF82 |=>
        led_sink_on == ($past(reg_wdata) & PC_MASK)) else $error("sink enable wrong");
    level_up_a: assert property (reg_wr && reg_addr == 12'hF83 |=>
        lvl_up == $past(reg_wdata)) else $error("upper level wrong");
    level_lo_a: assert property (reg_wr && reg_addr == 12'hF84 |=>
        lvl_lo == $past(reg_wdata)) else $error("lower level wrong");
    sel_first_a: assert property (reg_wr && reg_addr == 12'hFD0 && reg_wdata == 8'h07 ##1
        reg_wr && reg_addr == 12'hFD1 |=> first_select_bits[7:0] == $past(reg_wdata))
        else $error("first select wrong");
    sel_second_a: assert property (reg_wr && reg_addr == 12'hFD8 && reg_wdata == 8'h08 ##1
        reg_wr && reg_addr == 12'hFD9 |=> second_select_bits[23:16] == $past(reg_wdata))
        else $error("second select wrong");
    alt_data_a: assert property (((pin_out ^ alt_out) & alt_function_enable & ~pin_oe_n) == 0)
        else $error("alternate data not on pin");
    alt_release_a: assert property ((alt_function_enable & ~alt_oe & ~pin_oe_n) == 0)
        else $error("pin driven without alternate enable");
    reset_val_a: assert property ($rose(rst_n) |-> led_sink_on == 0 && led_sink_level == 0
        && &pin_oe_n) else $error("reset state wrong");
    cover property (reg_rd && reg_addr == 12'hFD2);
    cover property (|(alt_function_enable & ~pin_oe_n));
    cover property (reg_wr && reg_addr == 12'hF83);
endmodule // ppdl_chk
bind ppdl_top ppdl_chk #(.PA_MASK(PA_MASK), .PC_MASK(PC_MASK)) u_chk (.clk_sys(clk_sys),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .alt_out(alt_out), .alt_oe(alt_oe),
    .alt_function_enable(alt_function_enable), .first_select_bits(first_select_bits),
    .second_select_bits(second_select_bits), .led_sink_on(led_sink_on),
    .led_sink_level(led_sink_level));

// >>> tb/ppdl_pin_model.sv
// External pin model with pull-ups and an optional outside driver
`timescale 1ns/1ps
module ppdl_pin_model (
    input wire [23:0] pin_out,
    input wire [23:0] pin_oe_n,
    input wire [23:0] ext_val,
    input wire [23:0] ext_en,
    output wire [23:0] pin_in
);
    // Driven pins follow the block; released pins see the outside driver or the pull-up
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
        | (pin_oe_n & ~ext_en);
endmodule // ppdl_pin_model

// >>> tb/tb_port_pin_data_and_led_sink_control.sv
// Self-checking bench for the port and LED sink block
`timescale 1ns/1ps
module tb_port_pin_data_and_led_sink_control;
    localparam [7:0] PCM = 8'h0F;
    reg clk_sys = 1'b0;
    reg rst_n = 1'b0;
    reg [11:0] reg_addr = 12'h000;
    reg [7:0] reg_wdata = 8'h00;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg [23:0] alt_out = 24'h0;
    reg [23:0] alt_oe = 24'h0;
    reg [23:0] ext_val = 24'h0;
    reg [23:0] ext_en = 24'h0;
    wire [7:0] reg_rdata;
    wire [7:0] led_sink_on;
    wire [15:0] led_sink_level;
    wire [23:0] pin_in, pin_out, pin_oe_n, afe, fsel1, fsel2, fsel1_s;
    integer n_errors = 0;
    integer cmp_count = 0;
    integer i, c, p;
    reg [31:0] seed = 32'hC8BC3D1D;
    reg [11:0] b;
    reg [7:0] d, e, dv, dir, aen, od, ao, aoe, up, lo, drv, oen;
    ppdl_top #(.PC_MASK(PCM)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .alt_out(alt_out),
        .alt_oe(alt_oe), .alt_function_enable(afe), .first_select_bits(fsel1),
        .second_select_bits(fsel2), .led_sink_on(led_sink_on), .led_sink_level(led_sink_level));
    ppdl_pin_model pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_val(ext_val),
        .ext_en(ext_en), .pin_in(pin_in));
    // Smallest package copy on the same bus, watched only for its port A select reset
    ppdl_top #(.SMALL_PKG(1), .PC_MASK(PCM)) dut_small (.clk_sys(clk_sys), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(), .pin_in(pin_in), .pin_out(), .pin_oe_n(), .alt_out(alt_out),
        .alt_oe(alt_oe), .alt_function_enable(), .first_select_bits(fsel1_s),
        .second_select_bits(), .led_sink_on(), .led_sink_level());
    always #12.5 clk_sys = ~clk_sys;
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    task chk(input string nm, input [23:0] seen, input [23:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input [11:0] a, input [7:0] v);
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
    endtask
    task rd(input [11:0] a, output [7:0] q);
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask
    task idle();
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
    endtask
    task sub(input [11:0] base, input [7:0] ix, input [7:0] v);
        wr(base, ix);
        wr(base + 12'h001, v);
    endtask
    task conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Watchdog against a hung handshake
    initial begin
        #500000;
        n_errors++;
        conclude();
    end
    // Main sequence
    initial begin
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk("oe_n reset", pin_oe_n, 24'hFFFFFF);
        chk("select1 small", fsel1_s[7:0], 8'h04);
        for (i = 0; i < 6; i++) begin
            rd(12'(i < 3 ? 'hF82 + i : 'hFD3 + 4 * (i - 3)), d);
            chk("reset reg", d, 8'h00);
        end
        // Function select sub-registers of every port
        for (p = 0; p < 3; p++) begin
            b = 12'(12'hFD0 + 4 * p);
            wr(b, 8'h07);
            rd(b + 12'h001, d);
            chk("select1 reset", d, 8'h00);
            e = rnd();
            dv = rnd();
            sub(b, 8'h07, e);
            sub(b, 8'h08, dv);
            idle();
            chk("select1 out", fsel1[8*p +: 8], e);
            chk("select2 out", fsel2[8*p +: 8], dv);
            wr(b, 8'h08);
            rd(b + 12'h001, d);
            chk("select2 read", d, dv);
        end
        // Sampled inputs, missing pins and ignored writes
        ext_en <= 24'hFFFFFF;
        ext_val <= {rnd(), rnd(), rnd()};
        wr(12'hFD2, 8'hA5);
        wr(12'hFDA, 8'h5A);
        idle();
        idle();
        for (p = 0; p < 3; p++) begin
            rd(12'(12'hFD2 + 4 * p), d);
            chk("pin sample", d, ext_val[8*p +: 8] & (p == 2 ? PCM : 8'hFF));
        end
        rd(12'h100, d);
        chk("unmapped", d, 8'h00);
        // Random direction, alternate, open-drain and drive settings on port A
        ext_en <= 24'h0;
        for (i = 0; i < 12; i++) begin
            dir = rnd();
            aen = rnd();
            od = rnd();
            dv = rnd();
            ao = rnd();
            aoe = rnd();
            sub(12'hFD0, 8'h01, dir);
            sub(12'hFD0, 8'h02, aen);
            sub(12'hFD0, 8'h03, od);
            wr(12'hFD3, dv);
            alt_out <= {rnd(), rnd(), ao};
            alt_oe <= {rnd(), rnd(), aoe};
            idle();
            idle();
            drv = (aen & ao) | (~aen & dv);
            oen = ~((aen & aoe) | (~aen & ~dir)) | (od & drv);
            chk("oe_n", pin_oe_n[7:0], oen);
            chk("pin level", pin_out[7:0] | oen, drv | oen);
            chk("alt enable", afe[7:0], aen);
            rd(12'hFD2, d);
            chk("pin readback", d, drv | oen);
        end
        // Port C LED function chosen first, then sink enable and all level codes
        sub(12'hFD8, 8'h02, 8'hFF);
        for (c = 0; c < 5; c++) begin
            e = rnd();
            up = c < 4 ? {8{c[1]}} : rnd();
            lo = c < 4 ? {8{c[0]}} : rnd();
            wr(12'hF82, e);
            wr(12'hF83, up);
            wr(12'hF84, lo);
            idle();
            chk("sink on", led_sink_on, e & PCM);
            for (p = 0; p < 8; p++)
                chk("level", led_sink_level[2*p +: 2], 2 * up[p] + lo[p]);
            rd(12'hF82, d);
            chk("sink read", d, e);
            rd(12'hF84, d);
            chk("lower read", d, lo);
        end
        // Second reset in mid-run brings every register back to its reset value
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        chk("oe_n rerun", pin_oe_n, 24'hFFFFFF);
        chk("sink rerun", led_sink_on, 8'h00);
        chk("level rerun", led_sink_level, 16'h0000);
        chk("select1 rerun", fsel1_s[7:0], 8'h04);
        rd(12'hF83, d);
        chk("upper rerun", d, 8'h00);
        conclude();
    end
endmodule // tb_port_pin_data_and_led_sink_control
